// File: src/sar_adc_control_port.sv
// file: converter control port with result fifo
`timescale 1ns/100ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module sar_result_fifo #(
    parameter int WIDTH = 12,
    parameter int DEPTH = 32
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rst,
    // fill side
    input  wire logic             in_valid,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  in_ready,
    // drain side
    output logic                  out_valid,
    output logic [WIDTH-1:0]      out_data,
    input  wire logic             out_ready
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [AW:0]   count;
    } fifo_state_t;

    fifo_state_t      st;
    fifo_state_t      next_st;
    logic [WIDTH-1:0] mem [DEPTH];
    logic             push;
    logic             pop;

    assign in_ready  = (st.count != (AW+1)'(DEPTH));
    assign out_valid = (st.count != '0);
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign out_data  = mem[st.rd];

    always_comb begin
        next_st = st;
        if (push) begin
            next_st.wr = st.wr + 1'b1;
        end
        if (pop) begin
            next_st.rd = st.rd + 1'b1;
        end
        next_st.count = st.count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
        if (push) begin
            mem[st.wr] <= in_data;
        end
    end
endmodule

////////////////////////////////////////////////////////////////////////////////
module sar_adc_control_port #(
    parameter int BIT_CYCLES = sar_pkg::BIT_CYCLES
) (
    // clock and reset
    input  wire logic                          clk,
    input  wire logic                          rst,
    // host pins
    input  wire sar_pkg::host_pins_t           host,
    input  wire logic                          power_down_n,
    input  wire logic                          bipolar_mode,
    // analog core: comparator in, dac code and sample enable out
    input  wire logic                          comparator_high,
    output logic [sar_pkg::RES_BITS-1:0]       dac_code,
    output logic                               sample_enable,
    // result pins; out enable high while driving
    output var sar_pkg::result_pins_t          result,
    // result stream toward a downstream buffer
    output logic                               stream_valid,
    output logic [sar_pkg::RES_BITS-1:0]       stream_data,
    input  wire logic                          stream_ready,
    output logic                               stream_overflow
);
    localparam int N = sar_pkg::RES_BITS;

    typedef struct packed {
        sar_pkg::conv_state_t state;
        logic [N-1:0]         approximation_register;
        logic [N-1:0]         result_latch;
        logic [3:0]           bit_index;
        logic [7:0]           phase;
        logic                 overflow;
        logic [2:0]           sync1;
        logic [2:0]           sync2;
        logic                 start_prev;
        logic                 pd1;
        logic                 pd2;
    } ctrl_state_t;

    ctrl_state_t st;
    ctrl_state_t next_st;
    logic        cs_low;
    logic        start_edge;
    logic        fifo_in_ready;
    logic [N-1:0] trial;

    // sync1 fields feed sync2 only
    assign cs_low     = !st.sync2[2];
    assign start_edge = st.start_prev && !st.sync2[1] && cs_low && st.pd2;
    assign trial      = st.approximation_register | (N'(1) << st.bit_index);

    always_comb begin
        next_st            = st;
        next_st.sync1      = {host.chip_select_n, host.conversion_start_n, host.read_n};
        next_st.sync2      = st.sync1;
        next_st.pd1        = power_down_n;
        next_st.pd2        = st.pd1;
        next_st.start_prev = st.sync2[1];
        unique case (st.state)
            sar_pkg::ST_IDLE: begin
                // start edges outside idle are simply not looked at
                if (start_edge) begin
                    next_st.state                  = sar_pkg::ST_CONVERT;
                    next_st.approximation_register = '0;
                    next_st.bit_index              = sar_pkg::BIT_MSB_INDEX;
                    next_st.phase                  = sar_pkg::BIT_CNT_RESET;
                end
            end
            sar_pkg::ST_CONVERT: begin
                if (st.phase == 8'(BIT_CYCLES - 1)) begin
                    next_st.phase = '0;
                    if (!comparator_high) begin
                        next_st.approximation_register = trial;
                    end
                    if (st.bit_index == 4'h0) begin
                        next_st.state = sar_pkg::ST_LATCH;
                    end else begin
                        next_st.bit_index = st.bit_index - 4'h1;
                    end
                end else begin
                    next_st.phase = st.phase + 8'h01;
                end
            end
            sar_pkg::ST_LATCH: begin
                // offset binary to two's complement flips the msb
                next_st.result_latch = st.approximation_register
                                     ^ {bipolar_mode, {(N-1){1'b0}}};
                next_st.state        = sar_pkg::ST_IDLE;
                if (!fifo_in_ready) begin
                    next_st.overflow = 1'b1;
                end
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st       <= '0;
            st.sync1 <= 3'h7;
            st.sync2 <= 3'h7;
            st.start_prev <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    assign dac_code        = (st.state == sar_pkg::ST_CONVERT) ? trial : '0;
    assign sample_enable   = (st.state == sar_pkg::ST_IDLE);
    assign result.busy_n   = (st.state == sar_pkg::ST_IDLE);
    assign result.data_out = st.result_latch;
    assign result.data_oe  = {N{cs_low && !st.sync2[0]}};
    assign stream_overflow = st.overflow;

    // completed word is pushed as the latch loads; lost if the buffer is full
    sar_result_fifo #(.WIDTH(N), .DEPTH(sar_pkg::FIFO_DEPTH)) u_fifo (
        .clk       (clk),
        .rst       (rst),
        .in_valid  (st.state == sar_pkg::ST_LATCH),
        .in_data   (st.approximation_register ^ {bipolar_mode, {(N-1){1'b0}}}),
        .in_ready  (fifo_in_ready),
        .out_valid (stream_valid),
        .out_data  (stream_data),
        .out_ready (stream_ready)
    );

    ////////////////////////////////////////////////////////////////////////////
    busy_during_a: assert property (@(posedge clk) disable iff (rst)
        start_edge && st.state == sar_pkg::ST_IDLE |=> !result.busy_n [*8])
        else $error("busy rose too early");
    sar_clear_a: assert property (@(posedge clk) disable iff (rst)
        start_edge && st.state == sar_pkg::ST_IDLE |=> st.approximation_register == '0)
        else $error("approximation register not cleared");
    no_restart_a: assert property (@(posedge clk) disable iff (rst)
        st.state == sar_pkg::ST_CONVERT && st.phase != 8'(BIT_CYCLES - 1)
        |=> st.state == sar_pkg::ST_CONVERT)
        else $error("conversion restarted or cut");
    msb_first_a: assert property (@(posedge clk) disable iff (rst)
        $rose(st.state == sar_pkg::ST_CONVERT) |-> st.bit_index == 4'hb)
        else $error("first decision not msb");
    latch_copy_a: assert property (@(posedge clk) disable iff (rst)
        st.state == sar_pkg::ST_LATCH |=> result.data_out ==
        ($past(st.approximation_register) ^ {$past(bipolar_mode), {(N-1){1'b0}}}))
        else $error("latch not loaded");
    drive_gate_a: assert property (@(posedge clk) disable iff (rst)
        result.data_oe == {N{$past(!host.chip_select_n && !host.read_n, 2)}})
        else $error("outputs driven without read");
    cs_ignore_a: assert property (@(posedge clk) disable iff (rst)
        $past(host.chip_select_n, 2) && st.state == sar_pkg::ST_IDLE
        |=> st.state == sar_pkg::ST_IDLE)
        else $error("start taken with chip select high");
    all_bits_a: assert property (@(posedge clk) disable iff (rst)
        $rose(result.busy_n) |-> $past(st.state) == sar_pkg::ST_LATCH)
        else $error("busy rose before all decisions");
    start_take_a: assert property (@(posedge clk) disable iff (rst)
        start_edge && st.state == sar_pkg::ST_IDLE |=> st.state == sar_pkg::ST_CONVERT)
        else $error("start edge not taken");

    conv_done_c: cover property (@(posedge clk) disable iff (rst) $rose(result.busy_n));
    read_c: cover property (@(posedge clk) disable iff (rst) result.data_oe != '0);
    overflow_c: cover property (@(posedge clk) disable iff (rst) $rose(stream_overflow));
endmodule

`default_nettype wire

// File: src/sar_pkg.sv
// package: constants and carrier types for the converter control port
`default_nettype none
package sar_pkg;
    localparam int         RES_BITS       = 12;
    localparam int         CLK_PERIOD_NS  = 10;
    localparam int         BIT_TIME_NS    = 130;
    localparam int         BIT_CYCLES     = (BIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int         ACQ_TIME_NS    = 200;
    localparam int         ACQ_CYCLES     = (ACQ_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int         FIFO_DEPTH     = 32;
    localparam logic [3:0] BIT_MSB_INDEX  = 4'hb;
    localparam logic [7:0] BIT_CNT_RESET  = 8'h00;

    typedef enum logic [1:0] {ST_IDLE, ST_CONVERT, ST_LATCH} conv_state_t;

    typedef struct packed {
        logic                chip_select_n;
        logic                conversion_start_n;
        logic                read_n;
    } host_pins_t;

    typedef struct packed {
        logic [RES_BITS-1:0] data_out;
        logic [RES_BITS-1:0] data_oe;
        logic                busy_n;
    } result_pins_t;
endpackage
`default_nettype wire

// File: bench/sar_host_model.sv
// host bus model driving the converter strobes
`timescale 1ns/100ps
`default_nettype none
module sar_host_model (
    // bus side
    input  wire logic                  clk,
    input  wire sar_pkg::result_pins_t result,
    output var sar_pkg::host_pins_t    host
);
    initial host = 3'b111;
    // len is the busy low time in cycles, 0 if no conversion ran
    task automatic convert(input logic cs_n, again, output int len);
        len = 0;
        @(posedge clk) #1 host.chip_select_n = cs_n;
        @(posedge clk) #1 host.conversion_start_n = 1'b0;
        // every edge after which busy is seen low adds one cycle
        for (int i = 0; i < 4; i++) begin
            @(posedge clk) #1 len += int'(!result.busy_n);
        end
        host.conversion_start_n = 1'b1;
        for (int i = 0; i < 8 && len == 0; i++) begin
            @(posedge clk) #1 len += int'(!result.busy_n);
        end
        while (len != 0 && !result.busy_n && len < 999) begin
            // a second edge mid-run must leave the conversion alone
            if (again && len == 5) host.conversion_start_n = 1'b0;
            @(posedge clk) #1 len += int'(!result.busy_n);
        end
        host = 3'b111;
        repeat (sar_pkg::ACQ_CYCLES) @(posedge clk);
    endtask
    task automatic read(input logic cs_n);
        @(posedge clk) #1 host = '{cs_n, 1'b1, 1'b0};
        repeat (4) @(posedge clk);
        #1;
    endtask
endmodule
`default_nettype wire

// File: bench/sar_adc_control_port_tb.sv
// self-checking bench for the converter control port
`timescale 1ns/100ps
`default_nettype none
module sar_adc_control_port_tb;
    localparam int BC = 2;
    localparam int CONV = 12 * BC + 1;
    logic                  clk, rst, pd_n, bip, s_ready, s_valid, ovf, fill, s_en;
    logic [11:0]           analog, dac_code, s_data, exp;
    sar_pkg::host_pins_t   host;
    sar_pkg::result_pins_t result;
    int                    mismatches, comparisons, cycles, len;
    logic [11:0]           exp_q[$];

    sar_adc_control_port #(.BIT_CYCLES(BC)) sar_adc_control_port_i (
        .clk(clk), .rst(rst), .host(host), .power_down_n(pd_n),
        .bipolar_mode(bip), .comparator_high(dac_code > analog),
        .dac_code(dac_code), .sample_enable(s_en), .result(result),
        .stream_valid(s_valid), .stream_data(s_data),
        .stream_ready(s_ready), .stream_overflow(ovf)
    );
    sar_host_model sar_host_model_i (.clk(clk), .result(result), .host(host));

    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [11:0] got, want);
        comparisons++;
        if (got !== want) begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, got, want);
        end
    endtask
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic conv(input logic cs_n, again, run, push);
        #1 analog = 12'($urandom);
        bip = 1'($urandom);
        // bipolar: offset binary with the msb turned over
        exp = bip ? analog ^ 12'h800 : analog;
        // queued first: the word may leave the buffer before the task returns
        if (run && push) exp_q.push_back(exp);
        sar_host_model_i.convert(cs_n, again, len);
        check(12'(len), run ? 12'(CONV) : 12'h000);
        check({11'h0, s_en}, 12'h001);
        if (run) check(result.data_out, exp);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        if (!rst && s_valid && s_ready) check(s_data, exp_q.pop_front());
        #1 s_ready = fill ? 1'b0 : 1'($urandom);
        cycles++;
        if (cycles > 20000) begin
            mismatches++;
            end_sim();
        end
    end
    initial begin
        {rst, pd_n, bip, s_ready, fill, analog} = {5'b11000, 12'h000};
        mismatches  = 0;
        comparisons = 0;
        cycles      = 0;
        void'($urandom(27358));
        repeat (4) @(posedge clk);
        #1 rst = 0;
        check({11'h0, result.busy_n}, 12'h001);
        conv(1, 0, 0, 0);
        #1 pd_n = 0;
        conv(0, 0, 0, 0);
        #1 pd_n = 1;
        repeat (35) @(posedge clk);
        for (int i = 0; i < 12; i++) conv(0, 0, 1, 1);
        conv(0, 1, 1, 1);
        sar_host_model_i.read(1'b0);
        check(result.data_oe, 12'hfff);
        check(result.data_out, exp);
        sar_host_model_i.read(1'b1);
        check(result.data_oe, 12'h000);
        for (int i = 0; i < 300 && exp_q.size(); i++) @(posedge clk);
        check(12'(exp_q.size()), 12'h000);
        check({11'h0, ovf}, 12'h000);
        #1 fill = 1;
        for (int i = 0; i < 32; i++) conv(0, 0, 1, 1);
        conv(0, 0, 1, 0);
        check({11'h0, ovf}, 12'h001);
        #1 fill = 0;
        for (int i = 0; i < 400 && exp_q.size(); i++) @(posedge clk);
        check(12'(exp_q.size()), 12'h000);
        end_sim();
    end
endmodule
`default_nettype wire
